// ===== hdl/ltmc_pkg.sv
// What this block does
// R1 - Operation mode keeps transmitter, receiver and regulator all on.
// R2 - Chip select falling edge in operation mode enters power-down.
// R3 - Edge-wake variant connects pull-up only in operation; level-wake in every mode but power-on reset.
// R4 - Transmitter off when enable line low or permanent dominant seen.
// R5 - Transmitter re-enabled when enable line high, never while fault persists.
// R6 - Permanent dominant shutdown recovers once the dominant condition clears.
// R7 - Transmitter forced off while regulator unstable or recovering.
// R8 - Bus activity needs bus low continuously for the filter time.
// R9 - Level-wake leaves power-down on dominant longer than filter time.
// R10 - Edge-wake needs recessive-to-dominant edge then dominant filter time.
// R11 - Chip select high leaves power-down through ready mode.
// R12 - Edge-wake may go ready to transmitter-off; level-wake only to operation.
// R13 - Host drives enable low before chip select to reach transmitter-off.
// R14 - Power-on reset keeps all off, goes ready once supply is good.
// R15 - Ready keeps transmitter off; level-wake goes operation on chip select.
// R16 - Edge-wake ready picks operation or transmitter-off from enable line.
// R17 - Transmitter-off goes operation on enable high, power-down on select low.
// R18 - Power-down keeps transmitter, regulator off; bus wake goes to ready.
// R19 - Transmitter enabled only after chip select has been seen high.
// R20 - Chip select low at power-up leaves device waiting in ready mode.
// R21 - Receive data output tracks the bus line level.
// R22 - Supply below off threshold returns to power-on reset from any mode.
// R23 - Mismatch fault reported only after debounce following transmit fall.
// R24 - Wake variant is a build parameter; filter counts clock cycles.
// R25 - Reset starts in power-on reset, transmitter off, pull-up open.
`default_nettype none
package ltmc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WAKE_FILTER_US = 20;
  localparam int unsigned MISMATCH_DEBOUNCE_US = 25;
  // Least times convert to whole cycles, never fewer than one
  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_US * (CLK_HZ / 1_000_000) + 0) < 1 ? 1 :
    WAKE_FILTER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEBOUNCE_CYC =
    MISMATCH_DEBOUNCE_US * (CLK_HZ / 1_000_000) < 1 ? 1 :
    MISMATCH_DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

  // One-hot operating modes
  typedef enum logic [4:0] {
    LTMC_POR   = 5'h01,
    LTMC_READY = 5'h02,
    LTMC_OPER  = 5'h04,
    LTMC_TRANSMITTER_OFF_MODE = 5'h08,
    LTMC_PDOWN = 5'h10
  } ltmc_mode_e;

  // Power domain enables driven by the mode
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic reg_en;
    logic pullup_en;
  } ltmc_pwr_s;
endpackage
`default_nettype wire

// ===== hdl/ltmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ltmc_sync (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Async reset, active high
  input wire logic d_i,       // Asynchronous level
  output logic q_o            // Synchronised level
);
  logic meta_q;
  logic sync_q;
  // Two stages; the first is read only by the second
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule
`default_nettype wire

// ===== hdl/ltmc_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ltmc_filter #(
  parameter logic [ltmc_pkg::CNT_W-1:0] LEN =
    ltmc_pkg::CNT_W'(ltmc_pkg::WAKE_FILTER_CYC)
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Async reset, active high
  input wire logic level_i,   // Level to qualify
  output logic held_o         // Level stood for LEN cycles
);
  logic [ltmc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  // Count consecutive cycles; any drop restarts the count
  always_comb begin
    cnt_d = ltmc_pkg::CNT_ZERO;
    if (level_i) begin
      cnt_d = (cnt_q == LEN) ? cnt_q : cnt_q + ltmc_pkg::CNT_ONE;
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= ltmc_pkg::CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign held_o = (cnt_q == LEN);
endmodule
`default_nettype wire

// ===== hdl/ltmc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ltmc_mode_ctrl #(
  parameter bit EDGE_WAKE = 1'b0 // 1: edge-wake variant, 0: level-wake
) (
  input wire logic clk_sys_i,              // System clock
  input wire logic rst_i,                  // Async reset, active high
  input wire logic supply_on_i,            // Supply above on threshold
  input wire logic supply_off_i,           // Supply below off threshold
  input wire logic reg_stable_i,           // Regulated output stable
  input wire logic chip_select_local_wake_i, // Chip select / local wake
  input wire logic txd_i,                  // Transmit data from host
  input wire logic bus_line_i,             // Bus level, 1 recessive
  input wire logic fault_txe_i,            // Fault/enable line level
  input wire logic thermal_fault_i,        // Internal thermal/short fault
  input wire logic perm_dominant_i,        // Permanent dominant detected
  output logic fault_txe_o,                // Open-drain data, always 0
  output logic fault_txe_oe_o,             // High while pulling line low
  output logic bus_line_o,                 // Open-drain data, always 0
  output logic bus_line_oe_o,              // High while driving dominant
  output logic rxd_o,                      // Receive data
  output ltmc_pkg::ltmc_pwr_s pwr_o,       // Power domain enables
  output ltmc_pkg::ltmc_mode_e mode_o      // Current mode
);
  logic son_s, soff_s, rstab_s, cs_s, txd_s, bus_s, txe_s, flt_s, pd_s;
  logic dom_held, mis_held, mismatch;

  ltmc_sync u_s0 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(supply_on_i), .q_o(son_s));
  ltmc_sync u_s1 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(supply_off_i), .q_o(soff_s));
  ltmc_sync u_s2 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(reg_stable_i), .q_o(rstab_s));
  ltmc_sync u_s3 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(chip_select_local_wake_i), .q_o(cs_s));
  ltmc_sync u_s4 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(~txd_i), .q_o(txd_s));      // Inverted: 1 means txd low
  ltmc_sync u_s5 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(~bus_line_i), .q_o(bus_s)); // Inverted: 1 means dominant
  ltmc_sync u_s6 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(fault_txe_i), .q_o(txe_s));
  ltmc_sync u_s7 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(thermal_fault_i), .q_o(flt_s));
  ltmc_sync u_s8 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .d_i(perm_dominant_i), .q_o(pd_s));

  // Bus must stay dominant the full filter time to count as activity
  ltmc_filter #(
    .LEN(ltmc_pkg::CNT_W'(ltmc_pkg::WAKE_FILTER_CYC))
  ) u_wake_flt ( // R8 R24
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .level_i(bus_s),
    .held_o(dom_held)
  );

  // Transmit low while bus recessive: held past debounce before reporting
  assign mismatch = txd_s & ~bus_s;
  ltmc_filter #(
    .LEN(ltmc_pkg::CNT_W'(ltmc_pkg::DEBOUNCE_CYC))
  ) u_mis_flt ( // R23
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .level_i(mismatch),
    .held_o(mis_held)
  );

  ltmc_pkg::ltmc_mode_e mode_q, mode_d;
  logic cs_prev_q, cs_prev_d;
  logic armed_q, armed_d;     // Edge-wake: recessive seen, edge may follow
  logic cs_seen_q, cs_seen_d;
  logic drv_fault;

  // Device pulls the enable line low on thermal fault, mismatch or unstable regulator, outside power-on reset and power-down
  assign drv_fault = flt_s | mis_held | ~rstab_s;

  // Mode sequencing
  always_comb begin
    mode_d = mode_q;
    cs_prev_d = cs_s;
    cs_seen_d = cs_seen_q | cs_s;                              // R19
    // Arm on recessive; in edge-wake a dominant level with no prior recessive never wakes
    armed_d = armed_q;
    if (!bus_s) begin
      armed_d = 1'b1;                                          // R10
    end else if (mode_q != ltmc_pkg::LTMC_PDOWN) begin
      armed_d = 1'b0;
    end
    case (mode_q)
      ltmc_pkg::LTMC_POR: begin
        cs_seen_d = 1'b0;
        if (son_s) begin
          mode_d = ltmc_pkg::LTMC_READY;                       // R14
        end
      end
      ltmc_pkg::LTMC_READY: begin
        // Waits here while select low or regulator settling
        if (cs_s && rstab_s) begin                             // R20
          if (EDGE_WAKE && !txe_s) begin
            mode_d = ltmc_pkg::LTMC_TRANSMITTER_OFF_MODE;                     // R12 R16
          end else begin
            mode_d = ltmc_pkg::LTMC_OPER;                      // R15 R16
          end
        end
      end
      ltmc_pkg::LTMC_OPER: begin
        if (cs_prev_q && !cs_s) begin
          mode_d = ltmc_pkg::LTMC_PDOWN;                       // R2
        end else if (!txe_s || pd_s || drv_fault) begin
          mode_d = ltmc_pkg::LTMC_TRANSMITTER_OFF_MODE;                       // R4 R7
        end
      end
      ltmc_pkg::LTMC_TRANSMITTER_OFF_MODE: begin
        if (!cs_s) begin
          mode_d = ltmc_pkg::LTMC_PDOWN;                       // R17
        end else if (txe_s && !drv_fault && !pd_s) begin
          mode_d = ltmc_pkg::LTMC_OPER;                        // R5 R6 R17
        end
      end
      ltmc_pkg::LTMC_PDOWN: begin
        if (cs_s) begin
          mode_d = ltmc_pkg::LTMC_READY;                       // R11
        end else if (dom_held && (!EDGE_WAKE || armed_q)) begin
          mode_d = ltmc_pkg::LTMC_READY;                       // R9 R10 R18
        end
        if (mode_d == ltmc_pkg::LTMC_READY) begin
          armed_d = 1'b0;
        end
      end
      default: mode_d = ltmc_pkg::LTMC_POR;
    endcase
    if (soff_s) begin
      mode_d = ltmc_pkg::LTMC_POR;                             // R22
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q <= ltmc_pkg::LTMC_POR;                            // R25
      cs_prev_q <= 1'b0;
      armed_q <= 1'b0;
      cs_seen_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cs_prev_q <= cs_prev_d;
      armed_q <= armed_d;
      cs_seen_q <= cs_seen_d;
    end
  end

  // Output decode, registered so every output but the constant open-drain data leaves a flip-flop
  ltmc_pkg::ltmc_pwr_s pwr_q, pwr_d;
  logic bus_oe_q, bus_oe_d, fault_oe_q, fault_oe_d, rxd_q, rxd_d;
  ltmc_pkg::ltmc_mode_e mode_out_q;

  always_comb begin
    pwr_d = '0;
    case (mode_d)
      ltmc_pkg::LTMC_OPER: begin
        pwr_d.tx_en = cs_seen_d & txe_s & ~drv_fault & ~pd_s;  // R1 R19
        pwr_d.rx_en = 1'b1;
        pwr_d.reg_en = 1'b1;
      end
      ltmc_pkg::LTMC_READY, ltmc_pkg::LTMC_TRANSMITTER_OFF_MODE: begin
        pwr_d.rx_en = 1'b1;                                    // R15 R17
        pwr_d.reg_en = 1'b1;
      end
      default: pwr_d = '0;                                     // R14 R18
    endcase
    // Edge-wake opens the pull-up outside operation to save current
    pwr_d.pullup_en = EDGE_WAKE ? (mode_d == ltmc_pkg::LTMC_OPER)
                                : (mode_d != ltmc_pkg::LTMC_POR); // R3
    bus_oe_d = pwr_d.tx_en & txd_s;                            // R4
    fault_oe_d = (mode_d != ltmc_pkg::LTMC_POR) &&
                 (mode_d != ltmc_pkg::LTMC_PDOWN) && drv_fault;
    rxd_d = ~bus_s;                                            // R21
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= '0;                                             // R25
      bus_oe_q <= 1'b0;
      fault_oe_q <= 1'b0;
      rxd_q <= 1'b1;
      mode_out_q <= ltmc_pkg::LTMC_POR;
    end else begin
      pwr_q <= pwr_d;
      bus_oe_q <= bus_oe_d;
      fault_oe_q <= fault_oe_d;
      rxd_q <= rxd_d;
      mode_out_q <= mode_d;
    end
  end

  assign pwr_o = pwr_q;
  assign bus_line_oe_o = bus_oe_q;
  assign bus_line_o = 1'b0;
  assign fault_txe_oe_o = fault_oe_q;
  assign fault_txe_o = 1'b0;
  assign rxd_o = rxd_q;
  assign mode_o = mode_out_q;
endmodule
`default_nettype wire

// ===== tb/ltmc_mode_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ltmc_mode_ctrl_properties #(
  parameter bit EDGE_WAKE = 1'b0 // Variant checked
) (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic supply_on_i, // Supply good
  input wire logic supply_off_i, // Supply lost
  input wire logic reg_stable_i, // Regulator ok
  input wire logic chip_select_local_wake_i, // Select
  input wire logic txd_i, // Tx data
  input wire logic bus_line_i, // Bus level
  input wire logic fault_txe_i, // Enable line
  input wire logic thermal_fault_i, // Fault
  input wire logic perm_dominant_i, // Stuck bus
  input wire logic fault_txe_o, // Fault data
  input wire logic fault_txe_oe_o, // Fault drive
  input wire logic bus_line_o, // Bus data
  input wire logic bus_line_oe_o, // Bus drive
  input wire logic rxd_o, // Rx data
  input wire ltmc_pkg::ltmc_pwr_s pwr_o, // Enables
  input wire ltmc_pkg::ltmc_mode_e mode_o // Mode
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Each cause but the debounced mismatch that must keep the driver off; four samples cover sync delay
  logic tx_block;
  assign tx_block = !fault_txe_i || thermal_fault_i || perm_dominant_i ||
    !reg_stable_i;
  // Bus history is not valid until three edges have passed since reset
  logic [1:0] age_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end

  oper_power_a: assert property (
    mode_o == ltmc_pkg::LTMC_OPER |-> pwr_o.rx_en && pwr_o.reg_en)
    else $error("operation mode without receiver or regulator");
  por_off_a: assert property (
    mode_o == ltmc_pkg::LTMC_POR |-> pwr_o == 4'h0)
    else $error("power-on reset with a domain enabled");
  ready_power_a: assert property (
    mode_o == ltmc_pkg::LTMC_READY |->
      !pwr_o.tx_en && pwr_o.rx_en && pwr_o.reg_en)
    else $error("ready mode enables wrong");
  pdown_off_a: assert property (
    mode_o == ltmc_pkg::LTMC_PDOWN |-> !pwr_o.tx_en && !pwr_o.reg_en)
    else $error("power-down with driver or regulator on");
  pullup_mode_a: assert property (
    pwr_o.pullup_en == (EDGE_WAKE ? mode_o == ltmc_pkg::LTMC_OPER :
      mode_o != ltmc_pkg::LTMC_POR))
    else $error("pull-up state does not match mode");
  tx_gate_a: assert property (
    tx_block [*4] |-> !pwr_o.tx_en)
    else $error("driver enabled while blocked");
  select_low_a: assert property (
    (!chip_select_local_wake_i) [*4] |->
      mode_o != ltmc_pkg::LTMC_OPER && !pwr_o.tx_en)
    else $error("driver or operation kept with select low");
  supply_por_a: assert property (
    supply_off_i [*4] |-> mode_o == ltmc_pkg::LTMC_POR)
    else $error("supply loss did not return to power-on reset");
  rxd_track_a: assert property (
    age_q == 2'h3 |-> rxd_o == $past(bus_line_i, 3))
    else $error("receive data does not follow bus");
  bus_drive_a: assert property (
    bus_line_oe_o |-> pwr_o.tx_en && !bus_line_o && !fault_txe_o)
    else $error("bus driven without transmitter enabled");

  // Main paths through the mode graph, and the fault line drive
  cover property (mode_o == ltmc_pkg::LTMC_TRANSMITTER_OFF_MODE);
  cover property (mode_o == ltmc_pkg::LTMC_PDOWN ##1
    mode_o == ltmc_pkg::LTMC_READY);
  cover property ($rose(fault_txe_oe_o));
endmodule
`default_nettype wire

// ===== tb/ltmc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module ltmc_far_side (
  input wire logic host_low_i, // Host pulls enable low
  input wire logic node_dom_i, // Other node dominant
  input wire logic bus_short_i, // Bus shorted to battery
  input wire logic fault_oe_i, // Device pulls fault low
  input wire logic bus_oe_i, // Device drives dominant
  output logic fault_txe_o, // Resolved enable wire
  output logic bus_line_o // Resolved bus wire
);
  // Both wires have pull-ups, so any driver pulls them low
  assign fault_txe_o = !(host_low_i || fault_oe_i);
  // A battery short beats every driver, which makes a mismatch
  assign bus_line_o = bus_short_i || !(node_dom_i || bus_oe_i);
endmodule
`default_nettype wire

// ===== tb/lin_transceiver_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module lin_transceiver_mode_control_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic supply_on, supply_off, reg_stable, cs, txd;
  logic thermal, perm_dom, host_low, node_dom, bus_short;
  logic fault_oe [2];
  logic bus_oe [2];
  logic rxd [2];
  logic fault_w [2];
  logic bus_w [2];
  ltmc_pkg::ltmc_pwr_s pwr [2];
  ltmc_pkg::ltmc_mode_e mode [2];
  int fail_count = 0;
  int samples_checked = 0;

  // Free-running clock, 100 ns period
  always #50 clk_sys = !clk_sys;

  // Index 0 is level-wake, index 1 edge-wake
  for (genvar g = 0; g < 2; g++) begin : g_var
    ltmc_mode_ctrl #(.EDGE_WAKE(g == 1)) i_dut (
      .clk_sys_i(clk_sys), .rst_i(rst), .supply_on_i(supply_on),
      .supply_off_i(supply_off), .reg_stable_i(reg_stable),
      .chip_select_local_wake_i(cs), .txd_i(txd), .bus_line_i(bus_w[g]),
      .fault_txe_i(fault_w[g]), .thermal_fault_i(thermal),
      .perm_dominant_i(perm_dom), .fault_txe_o(),
      .fault_txe_oe_o(fault_oe[g]), .bus_line_o(), .bus_line_oe_o(bus_oe[g]),
      .rxd_o(rxd[g]), .pwr_o(pwr[g]), .mode_o(mode[g]));
    ltmc_far_side i_far (.host_low_i(host_low), .node_dom_i(node_dom),
      .bus_short_i(bus_short), .fault_oe_i(fault_oe[g]),
      .bus_oe_i(bus_oe[g]), .fault_txe_o(fault_w[g]), .bus_line_o(bus_w[g]));
  end

  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Inputs move only at falling edges
  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check_mode(int v, ltmc_pkg::ltmc_mode_e e);
    samples_checked++;
    if (mode[v] !== e) begin
      fail_count++;
      $display("unexpected mode %0d expected %h seen %h", v, e, mode[v]);
    end
  endtask

  task automatic check_pwr(int v, ltmc_pkg::ltmc_pwr_s e);
    samples_checked++;
    if (pwr[v] !== e) begin
      fail_count++;
      $display("unexpected pwr %0d expected %h seen %h", v, e, pwr[v]);
    end
  endtask

  task automatic check_bit(string n, logic e, logic s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", n, e, s);
    end
  endtask

  task automatic check_both(ltmc_pkg::ltmc_mode_e e);
    check_mode(0, e);
    check_mode(1, e);
  endtask

  task automatic set_fault(int k, logic v);
    case (k)
      0: host_low = v;
      1: thermal = v;
      2: perm_dom = v;
      default: reg_stable = !v;
    endcase
  endtask

  // Supply ramp with select low, then select raises operation
  task automatic s_power_up();
    step(4);
    check_both(ltmc_pkg::LTMC_POR);
    check_pwr(1, 4'h0);
    supply_on = 1'b1;
    reg_stable = 1'b1;
    step(24);
    check_both(ltmc_pkg::LTMC_READY);
    check_pwr(0, 4'h7);
    check_pwr(1, 4'h6);
    cs = 1'b1;
    step(4);
    check_both(ltmc_pkg::LTMC_OPER);
    check_pwr(1, 4'hF);
  endtask

  // Every shutdown cause but the mismatch in turn, each followed by recovery
  task automatic s_tx_faults();
    for (int k = 0; k < 4; k++) begin
      set_fault(k, 1'b1);
      step(4);
      check_bit("tx_en level", 1'b0, pwr[0].tx_en);
      check_bit("tx_en edge", 1'b0, pwr[1].tx_en);
      set_fault(k, 1'b0);
      step(10);
      check_pwr(0, 4'hF);
      check_pwr(1, 4'hF);
    end
  endtask

  // Bus held recessive by a short while the host sends dominant
  task automatic s_mismatch();
    bus_short = 1'b1;
    txd = 1'b0;
    step(200);
    check_bit("fault_oe early", 1'b0, fault_oe[0]);
    check_bit("bus_oe driving", 1'b1, bus_oe[0]);
    step(60);
    check_bit("fault_oe late", 1'b1, fault_oe[0]);
    check_bit("fault_oe late edge", 1'b1, fault_oe[1]);
    check_bit("bus_oe off", 1'b0, bus_oe[0]);
    txd = 1'b1;
    bus_short = 1'b0;
    step(12);
    check_both(ltmc_pkg::LTMC_OPER);
  endtask

  // Dominant under the filter time does not wake yet; held past it after an edge, it wakes
  task automatic s_bus_wake();
    cs = 1'b0;
    step(4);
    check_both(ltmc_pkg::LTMC_PDOWN);
    node_dom = 1'b1;
    step(150);
    check_both(ltmc_pkg::LTMC_PDOWN);
    check_bit("rxd dominant", 1'b0, rxd[0]);
    step(70);
    check_both(ltmc_pkg::LTMC_READY);
    node_dom = 1'b0;
    step(4);
    check_bit("rxd recessive", 1'b1, rxd[1]);
  endtask

  // Bus already dominant on entry: only level-wake may leave power-down
  task automatic s_stuck_bus();
    cs = 1'b1;
    step(6);
    check_both(ltmc_pkg::LTMC_OPER);
    node_dom = 1'b1;
    cs = 1'b0;
    step(220);
    check_mode(0, ltmc_pkg::LTMC_READY);
    check_mode(1, ltmc_pkg::LTMC_PDOWN);
    node_dom = 1'b0;
    step(4);
    check_mode(1, ltmc_pkg::LTMC_PDOWN);
  endtask

  // Host lowers enable before select to reach the quiet mode
  task automatic s_transmitter_off_mode();
    host_low = 1'b1;
    step(4);
    cs = 1'b1;
    step(6);
    check_mode(1, ltmc_pkg::LTMC_TRANSMITTER_OFF_MODE);
    check_pwr(1, 4'h6);
    host_low = 1'b0;
    step(8);
    check_mode(1, ltmc_pkg::LTMC_OPER);
    host_low = 1'b1;
    step(8);
    cs = 1'b0;
    step(4);
    check_both(ltmc_pkg::LTMC_PDOWN);
    host_low = 1'b0;
    cs = 1'b1;
    step(8);
    check_both(ltmc_pkg::LTMC_OPER);
  endtask

  task automatic s_supply_loss();
    supply_off = 1'b1;
    step(4);
    check_both(ltmc_pkg::LTMC_POR);
    supply_off = 1'b0;
    step(4);
  endtask

  // Watchdog far beyond the expected run of under a thousand cycles
  initial begin
    #(20000 * 100);
    fail_count++;
    stop_test();
  end

  initial begin
    {supply_on, supply_off, reg_stable, cs, thermal} = 5'h00;
    {perm_dom, host_low, node_dom, bus_short} = 4'h0;
    txd = 1'b1;
    step(2);
    rst = 1'b0;
    s_power_up();
    s_tx_faults();
    s_mismatch();
    s_bus_wake();
    s_stuck_bus();
    s_transmitter_off_mode();
    s_supply_loss();
    stop_test();
  end
endmodule

bind ltmc_mode_ctrl ltmc_mode_ctrl_properties #(.EDGE_WAKE(EDGE_WAKE)) i_prop (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .supply_on_i(supply_on_i),
  .supply_off_i(supply_off_i), .reg_stable_i(reg_stable_i),
  .chip_select_local_wake_i(chip_select_local_wake_i), .txd_i(txd_i),
  .bus_line_i(bus_line_i), .fault_txe_i(fault_txe_i),
  .thermal_fault_i(thermal_fault_i), .perm_dominant_i(perm_dominant_i),
  .fault_txe_o(fault_txe_o), .fault_txe_oe_o(fault_txe_oe_o),
  .bus_line_o(bus_line_o), .bus_line_oe_o(bus_line_oe_o), .rxd_o(rxd_o),
  .pwr_o(pwr_o), .mode_o(mode_o));
`default_nettype wire
